// *** hdl/idt_pkg.sv ***
package idt_pkg;
  // ----------------------------------------
  // Word layout
  // ----------------------------------------
  localparam int WORD_W = 24;
  localparam int OPC_LO = 16;
  localparam int OPC_W = 8;
  localparam int EXT_W = 16;
  // ----------------------------------------
  // Opcodes
  // ----------------------------------------
  localparam logic [7:0] OP_NOP = 8'h00;
  localparam logic [7:0] OP_GOTO_FAR = 8'h01;
  localparam logic [7:0] OP_CALL_FAR = 8'h02;
  localparam logic [7:0] OP_MOVE_DBL = 8'h03;
  localparam logic [7:0] OP_BRANCH = 8'h04;
  localparam logic [7:0] OP_BRANCH_CMP = 8'h05;
  localparam logic [7:0] OP_BRANCH_COND = 8'h06;
  localparam logic [7:0] OP_CALL_IND = 8'h07;
  localparam logic [7:0] OP_GOTO_IND = 8'h08;
  localparam logic [7:0] OP_TABLE_RD = 8'h09;
  localparam logic [7:0] OP_TABLE_WR = 8'h0A;
  localparam logic [7:0] OP_RETURN = 8'h0B;
  localparam logic [7:0] OP_RET_INT = 8'h0C;
  localparam logic [7:0] OP_SKIP = 8'h0D;
  // Upper opcode nibble selecting an operand class.
  localparam logic [3:0] GRP_CTRL = 4'h0;
  localparam logic [3:0] GRP_DEFAULT_WORKING_REG = 4'h1;
  localparam logic [3:0] GRP_FILE = 4'h2;
  localparam logic [3:0] GRP_BITLIT = 4'h3;
  localparam logic [3:0] GRP_BITIND = 4'h4;
  localparam logic [3:0] GRP_LITALU = 4'h5;
  localparam logic [3:0] GRP_LITMOV = 4'h6;
  localparam logic [3:0] GRP_MAC = 4'h7;
  localparam logic [3:0] GRP_SHLIT = 4'h8;
  localparam logic [3:0] GRP_SHREG = 4'h9;
  // ----------------------------------------
  // Operand field positions
  // ----------------------------------------
  localparam int F_BASE = 12;
  localparam int F_DMODE = 10;
  localparam int F_DST = 6;
  localparam int F_SMODE = 4;
  localparam int F_SRC = 0;
  localparam int F_FILE = 0;
  localparam int F_FWREG = 13;
  localparam int F_BITNUM = 12;
  localparam int F_LADST = 8;
  localparam int F_LANAMED = 7;
  localparam int F_LIT5 = 0;
  localparam int F_LMLIT = 4;
  localparam int F_LMDST = 0;
  localparam int F_ACC = 15;
  localparam int F_MULP = 12;
  localparam int F_XOP = 9;
  localparam int F_XDST = 7;
  localparam int F_YOP = 4;
  localparam int F_YDST = 2;
  localparam int F_AWB = 0;
  localparam int F_SHSRC = 8;
  localparam int F_SHLIT = 0;
  localparam logic [3:0] WORKING_REG_ZERO = 4'h0;
  // ----------------------------------------
  // Cycle counts
  // ----------------------------------------
  localparam logic [1:0] CYC_ONE = 2'h1;
  localparam logic [1:0] CYC_TAKEN = 2'h2;
  localparam logic [1:0] CYC_FLOW = 2'h2;
  localparam logic [1:0] CYC_RETURN = 2'h3;
  localparam logic [1:0] CYC_TWO_WORD = 2'h2;
  localparam logic [1:0] CYC_SKIP_ONE = 2'h2;
  localparam logic [1:0] CYC_SKIP_TWO = 2'h3;
  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [3:0] {
    CL_NOP, CL_DEFAULT_WORKING_REG, CL_FILE, CL_BITLIT, CL_BITIND, CL_LITALU, CL_LITMOV,
    CL_MAC, CL_SHLIT, CL_SHREG, CL_FLOW, CL_CONDBR, CL_SKIP, CL_TWOWORD,
    CL_ILLEGAL
  } idt_class_t;
  typedef enum logic [2:0] {
    ST_FIRST = 3'b001,
    ST_SECOND = 3'b010,
    ST_STALL = 3'b100
  } idt_state_t;
  typedef struct packed {
    logic [7:0] opcode;
    idt_class_t cls;
    logic twoWord;
    logic byteMode;
    logic [3:0] baseReg;
    logic [3:0] srcReg;
    logic [3:0] dstReg;
    logic [1:0] srcMode;
    logic [1:0] dstMode;
    logic [12:0] fileAddr;
    logic fileToWreg;
    logic [3:0] bitNum;
    logic bitFromReg;
    logic [15:0] literal;
    logic [3:0] resultReg;
    logic srcOverwrite;
    logic accSel;
    logic [2:0] mulPair;
    logic [2:0] xOp;
    logic [1:0] xDst;
    logic [2:0] yOp;
    logic [1:0] yDst;
    logic [1:0] awb;
    logic shiftFromReg;
    logic [5:0] shiftLit;
  } idt_fields_t;
endpackage

// *** hdl/idt_fields_if.sv ***
interface idt_fields_if;
  logic [23:0] word;
  idt_pkg::idt_fields_t fields;
  modport extract (
    input word,
    output fields
  );
  modport core (
    output word,
    input fields
  );
endinterface

// *** hdl/idt_field_extract.sv ***
module idt_field_extract (
  // Word in, fields out
  idt_fields_if.extract bus
);
  logic [23:0] w;
  logic [7:0] opc;
  idt_pkg::idt_fields_t f;

  assign w = bus.word;
  assign opc = w[idt_pkg::OPC_LO +: idt_pkg::OPC_W];
  assign bus.fields = f;

  function automatic idt_pkg::idt_class_t classOf(input logic [7:0] op);
    unique case (op[7:4])
      idt_pkg::GRP_DEFAULT_WORKING_REG: classOf = idt_pkg::CL_DEFAULT_WORKING_REG;
      idt_pkg::GRP_FILE: classOf = idt_pkg::CL_FILE;
      idt_pkg::GRP_BITLIT: classOf = idt_pkg::CL_BITLIT;
      idt_pkg::GRP_BITIND: classOf = idt_pkg::CL_BITIND;
      idt_pkg::GRP_LITALU: classOf = idt_pkg::CL_LITALU;
      idt_pkg::GRP_LITMOV: classOf = idt_pkg::CL_LITMOV;
      idt_pkg::GRP_MAC: classOf = idt_pkg::CL_MAC;
      idt_pkg::GRP_SHLIT: classOf = idt_pkg::CL_SHLIT;
      idt_pkg::GRP_SHREG: classOf = idt_pkg::CL_SHREG;
      idt_pkg::GRP_CTRL: begin
        unique case (op)
          idt_pkg::OP_NOP: classOf = idt_pkg::CL_NOP;
          idt_pkg::OP_GOTO_FAR, idt_pkg::OP_CALL_FAR,
          idt_pkg::OP_MOVE_DBL: classOf = idt_pkg::CL_TWOWORD;
          idt_pkg::OP_BRANCH_COND: classOf = idt_pkg::CL_CONDBR;
          idt_pkg::OP_SKIP: classOf = idt_pkg::CL_SKIP;
          idt_pkg::OP_BRANCH, idt_pkg::OP_BRANCH_CMP, idt_pkg::OP_CALL_IND,
          idt_pkg::OP_GOTO_IND, idt_pkg::OP_TABLE_RD, idt_pkg::OP_TABLE_WR,
          idt_pkg::OP_RETURN, idt_pkg::OP_RET_INT: classOf = idt_pkg::CL_FLOW;
          default: classOf = idt_pkg::CL_ILLEGAL;
        endcase
      end
      default: classOf = idt_pkg::CL_ILLEGAL;
    endcase
  endfunction

  always_comb begin
    f = '0;
    f.opcode = opc;
    f.cls = classOf(opc);
    f.twoWord = (f.cls == idt_pkg::CL_TWOWORD);
    f.byteMode = opc[0];
    unique case (f.cls)
      idt_pkg::CL_DEFAULT_WORKING_REG: begin
        f.baseReg = w[idt_pkg::F_BASE +: 4];
        f.srcReg = w[idt_pkg::F_SRC +: 4];
        f.srcMode = w[idt_pkg::F_SMODE +: 2];
        f.dstReg = w[idt_pkg::F_DST +: 4];
        f.dstMode = w[idt_pkg::F_DMODE +: 2];
        f.resultReg = f.dstReg;
      end
      idt_pkg::CL_FILE: begin
        f.fileAddr = w[idt_pkg::F_FILE +: 13];
        f.fileToWreg = w[idt_pkg::F_FWREG];
        f.resultReg = idt_pkg::WORKING_REG_ZERO;
      end
      idt_pkg::CL_BITLIT, idt_pkg::CL_BITIND: begin
        f.srcReg = w[idt_pkg::F_SRC +: 4];
        f.srcMode = w[idt_pkg::F_SMODE +: 2];
        f.bitFromReg = (f.cls == idt_pkg::CL_BITIND);
        f.bitNum = f.bitFromReg ? 4'h0 : w[idt_pkg::F_BITNUM +: 4];
        f.baseReg = f.bitFromReg ? w[idt_pkg::F_BITNUM +: 4] : 4'h0;
      end
      idt_pkg::CL_LITALU: begin
        f.baseReg = w[idt_pkg::F_BASE +: 4];
        f.dstReg = w[idt_pkg::F_LADST +: 4];
        f.literal = {11'h000, w[idt_pkg::F_LIT5 +: 5]};
        f.resultReg = w[idt_pkg::F_LANAMED] ? f.dstReg : f.baseReg;
        f.srcOverwrite = (f.resultReg == f.baseReg);
      end
      idt_pkg::CL_LITMOV: begin
        f.literal = {4'h0, w[idt_pkg::F_LMLIT +: 12]};
        f.dstReg = w[idt_pkg::F_LMDST +: 4];
        f.resultReg = f.dstReg;
      end
      idt_pkg::CL_MAC: begin
        f.accSel = w[idt_pkg::F_ACC];
        f.mulPair = w[idt_pkg::F_MULP +: 3];
        f.xOp = w[idt_pkg::F_XOP +: 3];
        f.xDst = w[idt_pkg::F_XDST +: 2];
        f.yOp = w[idt_pkg::F_YOP +: 3];
        f.yDst = w[idt_pkg::F_YDST +: 2];
        f.awb = w[idt_pkg::F_AWB +: 2];
      end
      idt_pkg::CL_SHLIT, idt_pkg::CL_SHREG: begin
        f.accSel = w[idt_pkg::F_ACC];
        f.srcReg = w[idt_pkg::F_SHSRC +: 4];
        f.shiftFromReg = (f.cls == idt_pkg::CL_SHREG);
        f.shiftLit = w[idt_pkg::F_SHLIT +: 6];
      end
      default: begin
        f.literal = w[idt_pkg::F_FILE +: 16];
      end
    endcase
  end
endmodule

// *** hdl/idt_decode_timing.sv ***
// Overview of operation
// - Every 24-bit instruction word is taken in a single fetch.
// - A single word holds an 8-bit opcode and one or more operand fields.
// - Exactly three opcodes span two words and all others span one.
// - A two-word instruction spans 48 bits and its second word has a zero top byte.
// - A second word met on its own decodes as a no-operation.
// - A plain single-word instruction finishes in one cycle.
// - A true condition or a changed program counter adds one or two no-operation cycles.
// - Branches, indirect calls and gotos, table accesses and returns take two or three cycles.
// - A taken skip costs two cycles over a one-word and three over a two-word target.
// - Every two-word instruction takes exactly two cycles.
// - Three-operand instructions use a plain base source, a second source and a destination.
// - File instructions name a file address and write it or the default register.
// - Bit instructions take the bit number from a literal or from the base register.
// - Literal arithmetic writes a named destination when its named bit is set, else the base source.
// - Multiply-accumulate instructions carry accumulator, operand and prefetch roles.
// - Other DSP instructions take the shift from a register or from a literal.
module idt_decode_timing (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Program memory words
  input wire logic [23:0] instrWord,
  input wire logic wordValid,
  // Execution feedback
  input wire logic condTrue,
  // Decoded instruction
  output idt_pkg::idt_fields_t decoded,
  output logic [15:0] secondWord,
  output logic secondWordBad,
  // Timing
  output logic issue,
  output logic execNop,
  output logic [1:0] cycleTotal,
  output logic [1:0] cycleIndex,
  output logic awaitSecond
);
  // ----------------------------------------
  // Field extraction
  // ----------------------------------------
  idt_fields_if fbus ();
  idt_pkg::idt_fields_t cur;

  assign fbus.word = instrWord;
  assign cur = fbus.fields;

  idt_field_extract u_extract (
    .bus(fbus)
  );

  // ----------------------------------------
  // Cycle cost
  // ----------------------------------------
  function automatic logic [1:0] costOf(input idt_pkg::idt_fields_t fl, input logic cond);
    logic [1:0] c;
    c = idt_pkg::CYC_ONE;
    unique case (fl.cls)
      idt_pkg::CL_FLOW: begin
        // flow changes take two or three
        if (fl.opcode == idt_pkg::OP_RETURN || fl.opcode == idt_pkg::OP_RET_INT) begin
          c = idt_pkg::CYC_RETURN;
        end else begin
          c = idt_pkg::CYC_FLOW;
        end
      end
      idt_pkg::CL_CONDBR: c = cond ? idt_pkg::CYC_TAKEN : idt_pkg::CYC_ONE;
      idt_pkg::CL_SKIP: c = cond ? idt_pkg::CYC_SKIP_ONE : idt_pkg::CYC_ONE;
      idt_pkg::CL_TWOWORD: c = idt_pkg::CYC_TWO_WORD;
      default: c = idt_pkg::CYC_ONE;
    endcase
    return c;
  endfunction

  // ----------------------------------------
  // Sequencing state
  // ----------------------------------------
  idt_pkg::idt_state_t state;
  idt_pkg::idt_state_t next_state;
  logic [1:0] stallCnt;
  logic [1:0] next_stallCnt;
  logic squash;
  logic squashSecond;
  logic firstTaken;
  logic [1:0] cost;

  assign firstTaken = (state == idt_pkg::ST_FIRST) && wordValid;
  assign cost = costOf(cur, condTrue);

  always_comb begin
    next_state = state;
    next_stallCnt = stallCnt;
    unique case (state)
      idt_pkg::ST_FIRST: begin
        if (wordValid) begin
          if (cur.twoWord) begin
            next_state = idt_pkg::ST_SECOND;
          end else if (!squash && cur.cls != idt_pkg::CL_SKIP && cost != idt_pkg::CYC_ONE) begin
            next_state = idt_pkg::ST_STALL;
            next_stallCnt = cost - idt_pkg::CYC_TAKEN;
          end
        end
      end
      idt_pkg::ST_SECOND: begin
        if (wordValid) begin
          next_state = idt_pkg::ST_FIRST;
        end
      end
      idt_pkg::ST_STALL: begin
        if (stallCnt == 2'h0) begin
          next_state = idt_pkg::ST_FIRST;
        end else begin
          next_stallCnt = stallCnt - 2'h1;
        end
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state <= idt_pkg::ST_FIRST;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      stallCnt <= 2'h0;
    end else begin
      stallCnt <= next_stallCnt;
    end
  end

  // Skip handling: the word after a taken skip is dropped, and its second word too.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      squash <= 1'b0;
    end else if (firstTaken) begin
      squash <= !squash && cur.cls == idt_pkg::CL_SKIP && condTrue;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      squashSecond <= 1'b0;
    end else if (firstTaken) begin
      squashSecond <= squash && cur.twoWord;
    end else if (state == idt_pkg::ST_SECOND && wordValid) begin
      squashSecond <= 1'b0;
    end
  end

  // ----------------------------------------
  // Decoded outputs
  // ----------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      decoded <= '0;
    end else if (firstTaken && !squash) begin
      decoded <= cur;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      secondWord <= 16'h0000;
    end else if (state == idt_pkg::ST_SECOND && wordValid && !squashSecond) begin
      secondWord <= instrWord[idt_pkg::EXT_W-1:0];
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      secondWordBad <= 1'b0;
    end else if (state == idt_pkg::ST_SECOND && wordValid) begin
      secondWordBad <= !squashSecond && (cur.opcode != idt_pkg::OP_NOP);
    end else if (firstTaken) begin
      secondWordBad <= 1'b0;
    end
  end

  // ----------------------------------------
  // Timing outputs
  // ----------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      issue <= 1'b0;
    end else begin
      issue <= firstTaken && !squash;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      execNop <= 1'b0;
    end else begin
      unique case (state)
        idt_pkg::ST_FIRST: begin
          execNop <= wordValid && (squash || cur.cls == idt_pkg::CL_NOP
                     || cur.cls == idt_pkg::CL_ILLEGAL);
        end
        idt_pkg::ST_SECOND: execNop <= wordValid && squashSecond;
        idt_pkg::ST_STALL: execNop <= 1'b1;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cycleTotal <= idt_pkg::CYC_ONE;
    end else if (firstTaken) begin
      if (squash) begin
        // two or three by target size
        cycleTotal <= cur.twoWord ? idt_pkg::CYC_SKIP_TWO : idt_pkg::CYC_SKIP_ONE;
      end else begin
        cycleTotal <= cost;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cycleIndex <= 2'h0;
    end else if (firstTaken) begin
      cycleIndex <= squash ? 2'h1 : 2'h0;
    end else if ((state == idt_pkg::ST_SECOND && wordValid) || state == idt_pkg::ST_STALL) begin
      cycleIndex <= cycleIndex + 2'h1;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      awaitSecond <= 1'b0;
    end else begin
      awaitSecond <= (next_state == idt_pkg::ST_SECOND);
    end
  end
endmodule

// *** sim/idt_prog_mem.sv ***
module idt_prog_mem (
  // Clock
  input wire logic mclk,
  // Fetched word towards the decoder
  output logic [23:0] instrWord,
  output logic wordValid,
  output logic condTrue
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [25:0] fifo[$];
  logic [25:0] item;
  initial begin
    instrWord = 24'h00_0000;
    wordValid = 1'b0;
    condTrue = 1'b0;
  end
  // A cleared valid bit queues a bubble, so the memory can answer slowly.
  function void push(input logic [23:0] w, input logic c, input logic v);
    fifo.push_back({v, c, w});
  endfunction
  // ----------------------------------------
  // Word delivery
  // ----------------------------------------
  // whole words, one per cycle
  always @(negedge mclk) begin
    if (fifo.size() > 0) begin
      item = fifo.pop_front();
      instrWord <= item[23:0];
      condTrue <= item[24];
      wordValid <= item[25];
    end else begin
      // An idle bus inverts the last word and condition each cycle, with valid low.
      instrWord <= ~instrWord;
      condTrue <= ~condTrue;
      wordValid <= 1'b0;
    end
  end
endmodule

// *** sim/idt_decode_timing_chk.sv ***
module idt_decode_timing_chk (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Inputs
  input wire logic [23:0] instrWord,
  input wire logic wordValid,
  input wire logic condTrue,
  // Outputs
  input idt_pkg::idt_fields_t decoded,
  input wire logic [15:0] secondWord,
  input wire logic secondWordBad,
  input wire logic issue,
  input wire logic execNop,
  input wire logic [1:0] cycleTotal,
  input wire logic [1:0] cycleIndex,
  input wire logic awaitSecond
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  logic flowTwo;
  logic isRet;
  logic isTwo;
  assign flowTwo = decoded.opcode inside {8'h04, 8'h05, [8'h07:8'h0A]};
  assign isRet = decoded.opcode inside {8'h0B, 8'h0C};
  assign isTwo = decoded.opcode inside {[8'h01:8'h03]};
  sequence stallAt(logic [1:0] idx);
    execNop && !issue && cycleIndex == idx;
  endsequence
  chk_flow_stall_two: assert property (
    issue && flowTwo |-> cycleTotal == 2'h2 ##1 stallAt(2'h1))
    else $error("flow change did not stall one cycle");
  chk_return_stall_three: assert property (
    issue && isRet |-> cycleTotal == 2'h3 ##1 stallAt(2'h1) ##1 stallAt(2'h2))
    else $error("return did not stall two cycles");
  chk_two_word_total: assert property (
    issue && isTwo |-> cycleTotal == 2'h2 && awaitSecond && decoded.twoWord)
    else $error("two-word instruction timing wrong");
  chk_opcode_top_byte: assert property (
    issue |-> $past(wordValid) && decoded.opcode == $past(instrWord[23:16]))
    else $error("opcode not from top byte");
  chk_single_cycle: assert property (
    issue && decoded.opcode[7:4] inside {[4'h1:4'h9]}
      |-> cycleTotal == 2'h1 && cycleIndex == 2'h0 && !execNop)
    else $error("plain instruction not single cycle");
  chk_cond_branch_total: assert property (
    issue && decoded.opcode == 8'h06 |-> cycleTotal == ($past(condTrue) ? 2'h2 : 2'h1))
    else $error("conditional branch cycle count wrong");
  chk_second_word_top: assert property (
    awaitSecond && !execNop && wordValid |=> secondWord == $past(instrWord[15:0])
      && secondWordBad == ($past(instrWord[23:16]) != 8'h00))
    else $error("second word capture wrong");
  chk_skip_squash: assert property (
    issue && decoded.opcode == 8'h0D && $past(condTrue) && wordValid |=> stallAt(2'h1))
    else $error("taken skip did not squash next word");
  chk_nop_alone: assert property (
    issue && decoded.opcode == 8'h00 |-> execNop && decoded.cls == idt_pkg::CL_NOP)
    else $error("zero-topped word not a no-operation");
  chk_default_working_reg_roles: assert property (
    issue && decoded.cls == idt_pkg::CL_DEFAULT_WORKING_REG |-> decoded.baseReg == $past(instrWord[15:12])
      && decoded.dstReg == $past(instrWord[9:6]))
    else $error("three-operand roles wrong");
endmodule
bind idt_decode_timing idt_decode_timing_chk u_chk (.mclk, .rst_n, .instrWord, .wordValid,
  .condTrue, .decoded, .secondWord, .secondWordBad, .issue, .execNop, .cycleTotal,
  .cycleIndex, .awaitSecond);

// *** sim/tb_top.sv ***
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [23:0] instrWord;
  logic wordValid;
  logic condTrue;
  idt_pkg::idt_fields_t decoded;
  logic [15:0] secondWord;
  logic secondWordBad;
  logic issue;
  logic execNop;
  logic [1:0] cycleTotal;
  logic [1:0] cycleIndex;
  logic awaitSecond;
  int err_total = 0;
  int checks = 0;
  logic [15:0] lfsr = 16'h0002;
  logic [15:0] r;
  logic [3:0] grp;
  always #20 mclk = ~mclk;
  idt_prog_mem u_mem (.mclk(mclk), .instrWord(instrWord), .wordValid(wordValid),
    .condTrue(condTrue));
  idt_decode_timing u_dut (.mclk(mclk), .rst_n(rst_n), .instrWord(instrWord),
    .wordValid(wordValid), .condTrue(condTrue), .decoded(decoded), .secondWord(secondWord),
    .secondWordBad(secondWordBad), .issue(issue), .execNop(execNop),
    .cycleTotal(cycleTotal), .cycleIndex(cycleIndex), .awaitSecond(awaitSecond));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function logic [15:0] nextRand();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr;
  endfunction
  function logic isBad(input logic [7:0] op);
    return op[7:4] >= 4'hA || (op[7:4] == 4'h0 && op > 8'h0D);
  endfunction
  function logic [1:0] expTotal(input logic [7:0] op, input logic c, input logic nextTwo);
    if (op inside {[8'h01:8'h05], [8'h07:8'h0A]}) return 2'h2;
    if (op inside {8'h0B, 8'h0C}) return 2'h3;
    if (op == 8'h06) return c ? 2'h2 : 2'h1;
    if (op == 8'h0D) return c ? (nextTwo ? 2'h3 : 2'h2) : 2'h1;
    return 2'h1;
  endfunction
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chkFields(input logic [23:0] w);
    idt_pkg::idt_fields_t d;
    d = decoded;
    case (w[23:20])
      idt_pkg::GRP_DEFAULT_WORKING_REG: begin
        check(24'({d.baseReg, d.srcReg, d.dstReg, d.srcMode, d.dstMode, d.byteMode}),
          24'({w[15:12], w[3:0], w[9:6], w[5:4], w[11:10], w[16]}));
      end
      idt_pkg::GRP_FILE: check(24'({d.fileToWreg, d.fileAddr}), 24'(w[13:0]));
      idt_pkg::GRP_BITLIT: check(24'({d.bitFromReg, d.bitNum}), 24'(w[15:12]));
      idt_pkg::GRP_BITIND: check(24'({d.bitFromReg, d.baseReg}), {19'h1, w[15:12]});
      idt_pkg::GRP_LITALU: begin
        check(24'({d.srcOverwrite, d.resultReg}),
          24'({!w[7] || w[11:8] == w[15:12], w[7] ? w[11:8] : w[15:12]}));
      end
      idt_pkg::GRP_LITMOV: begin
        check(24'({d.literal, d.dstReg}), 24'({4'h0, w[15:4], w[3:0]}));
      end
      idt_pkg::GRP_MAC: begin
        check(24'({d.accSel, d.mulPair, d.xOp, d.xDst, d.yOp, d.yDst, d.awb}),
          24'(w[15:0]));
      end
      idt_pkg::GRP_SHLIT: check(24'({d.shiftFromReg, d.shiftLit}), 24'(w[5:0]));
      idt_pkg::GRP_SHREG: check(24'(d.shiftFromReg), 24'h00_0001);
      default: ;
    endcase
  endtask
  // ----------------------------------------
  // One instruction with two following words
  // ----------------------------------------
  task automatic runOne(input logic [23:0] w, input logic c, input logic [23:0] f1);
    logic [7:0] op;
    logic [1:0] tot;
    op = w[23:16];
    tot = expTotal(op, c, f1[23:16] inside {[8'h01:8'h03]});
    @(posedge mclk);
    u_mem.push(w, c, 1'b1);
    u_mem.push(f1, 1'b0, 1'b1);
    u_mem.push(24'h00_0000, 1'b0, 1'b1);
    repeat (2) @(negedge mclk);
    check(24'(issue), 24'h00_0001);
    check(24'(decoded.opcode), 24'(op));
    check(24'(cycleTotal), 24'(expTotal(op, c, 1'b0)));
    check(24'(cycleIndex), 24'h00_0000);
    check(24'(execNop), 24'(op == 8'h00 || isBad(op)));
    check(24'(awaitSecond), 24'(op inside {[8'h01:8'h03]}));
    chkFields(w);
    @(negedge mclk);
    if (op inside {[8'h01:8'h03]}) begin
      check(24'({secondWordBad, secondWord}), 24'({f1[23:16] != 8'h00, f1[15:0]}));
      check(24'(cycleIndex), 24'h00_0001);
    end else if (tot > 2'h1) begin
      check(24'({issue, execNop, cycleIndex, cycleTotal}), 24'({2'b01, 2'h1, tot}));
    end else begin
      check(24'(issue), 24'h00_0001);
    end
    if (tot == 2'h3) begin
      @(negedge mclk);
      check(24'({issue, execNop, cycleIndex}), 24'({2'b01, 2'h2}));
    end
    repeat (5) @(negedge mclk);
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (6) @(posedge mclk);
    @(negedge mclk);
    check(24'({issue, execNop, awaitSecond, secondWordBad, cycleIndex}), 24'h00_0000);
    check(24'({cycleTotal, decoded.opcode}), 24'h00_0100);
    check(24'(secondWord), 24'h00_0000);
    rst_n = 1'b1;
    for (int op = 0; op < 14; op++) begin
      runOne({8'(op), 16'h5A3C}, 1'b0, 24'h00_1234);
      runOne({8'(op), 16'hC3A5}, 1'b1, 24'h00_4321);
    end
    runOne(24'h03_0000, 1'b0, 24'h12_3456);
    runOne(24'h0D_0000, 1'b1, 24'h01_0000);
    runOne(24'hA0_0000, 1'b0, 24'h00_0000);
    runOne(24'h0E_FFFF, 1'b0, 24'h00_0000);
    runOne(24'h50_5580, 1'b0, 24'h00_0000);
    runOne(24'h60_ABC7, 1'b0, 24'h00_0000);
    repeat (60) begin
      r = nextRand();
      grp = 4'(r % 10);
      runOne({grp, grp == 4'h0 ? 4'(r[7:4] % 14) : r[7:4], nextRand()}, r[15],
        r[14] ? 24'h01_0000 : 24'h00_0000);
    end
    tally_and_finish();
  end
  initial begin
    #(40 * 2500);
    err_total++;
    tally_and_finish();
  end
endmodule
